// ---- vca_vc_arb_regs.sv ----
// How it works
// - writing one to the load bit while no load is running copies the programmed table into the arbiter.
// - the load bit always reads back as zero.
// - selector codes zero and one are accepted as supported schemes.
// - other selector codes act as the default scheme; selector resets to zero.
// - any software write to a VC arbitration table entry sets the status flag.
// - status flag clears when the table load finishes; it resets to zero.
// - VC arbitration capability is 00h with zero extended VCs, 03h with one.
// - table offset in bits 31:24 is 03h with one extended VC, else 00h.
// - WRR with 32 phases is offered only when the low-priority group is nonzero.
// - port arbitration capability of resource zero reads 09h.
// - time-based WRR is never advertised on the default VC resource.
// - maximum time slots field in bits 22:16 reads 7Fh.
// - port arbitration table offset reads 04h in sixteen-byte units.
// - bits 14 and 15 of resource capability zero read as zero.
// - bits 2:0 of capability one report the extended VC count.
`timescale 1ns/1ps
`include "vca_consts.svh"

module vca_vc_arb_regs #(
    parameter int PHASES  = `VCA_TBL_PHASES,
    parameter int ENTRY_W = `VCA_TBL_ENTRY_W
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    input  wire logic [`VCA_ADDR_W-1:0]      regAddr,
    input  wire logic [`VCA_DATA_W-1:0]      regWrData,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [`VCA_DATA_W-1:0]      regRdData,
    input  wire logic [2:0]                  extVcCount,
    input  wire logic [2:0]                  lowPriorityVcGroup,
    output vca_pkg::vca_arb_cfg_t            arbCfg,
    output logic      [PHASES*ENTRY_W-1:0]   arbTable
);

    localparam int TBL_BITS = PHASES * ENTRY_W;
    localparam int WORDS    = (TBL_BITS + `VCA_DATA_W - 1) / `VCA_DATA_W;
    localparam int IDX_W    = (WORDS > 1) ? $clog2(WORDS) : 1;

    ////////////////////////////////////////////////////////////////////////////
    // count inputs, registered so every count-based capability field comes from a flop

    logic [2:0] extCount_q, extCount_d;
    logic [2:0] low_priority_vc_group_q,     low_priority_vc_group_d;

    always_comb begin
        extCount_d = extVcCount;
        low_priority_vc_group_d     = lowPriorityVcGroup;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            extCount_q <= 3'h0;
            low_priority_vc_group_q     <= 3'h0;
        end else begin
            extCount_q <= extCount_d;
            low_priority_vc_group_q     <= low_priority_vc_group_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capability words, all read-only

    logic                      oneExtVc;
    logic [7:0]                vcArbCap;
    logic [7:0]                vcTblOff;
    logic [`VCA_ADDR_W-1:0]    tblBase;
    logic [`VCA_DATA_W-1:0]    cap1Word;
    logic [`VCA_DATA_W-1:0]    cap2Word;
    logic [`VCA_DATA_W-1:0]    resCap0Word;

    always_comb begin
        oneExtVc = (extCount_q == 3'h1);
        vcArbCap = oneExtVc ? `VCA_VC_ARB_CAP_ONE : `VCA_VC_ARB_CAP_NONE;
        vcTblOff = oneExtVc ? `VCA_VC_TBL_OFF_ONE : `VCA_VC_TBL_OFF_NONE;
        tblBase  = `VCA_CAP_BASE
                 + (`VCA_ADDR_W'(vcTblOff) << `VCA_UNIT_SHIFT);

        cap1Word = '0;
        cap1Word[`VCA_CAP1_EXT_LSB +: 3]    = extCount_q;
        cap1Word[`VCA_CAP1_LOW_PRIORITY_VC_GROUP_LSB +: 3]   = low_priority_vc_group_q;
        cap1Word[`VCA_CAP1_ENTRY_LSB +: 2]  = `VCA_CAP1_ENTRY_SIZE;

        cap2Word = '0;
        cap2Word[`VCA_CAP2_ARBCAP_LSB +: 8] = vcArbCap;
        cap2Word[`VCA_CAP2_TBLOFF_LSB +: 8] = vcTblOff;

        // the default resource never advertises time-based WRR
        resCap0Word = '0;
        resCap0Word[`VCA_RC0_PORTCAP_LSB +: 8] = `VCA_PORT_ARB_CAP0;
        resCap0Word[`VCA_RC0_APS_BIT]          = 1'b0;
        resCap0Word[`VCA_RC0_SNOOP_BIT]        = 1'b0;
        resCap0Word[`VCA_RC0_SLOTS_LSB +: 7]   = `VCA_MAX_TIME_SLOTS;
        resCap0Word[`VCA_RC0_TBLOFF_LSB +: 8]  = `VCA_PORT_TBL_OFF0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic                   hitCtrl;
    logic                   hitCap1;
    logic                   hitCap2;
    logic                   hitRes0;
    logic                   hitTbl;
    logic [`VCA_ADDR_W-1:0] tblRel;
    logic [IDX_W-1:0]       tblIdx;

    always_comb begin
        hitCtrl = (regAddr == `VCA_OFF_PVC_CTRL_STAT);
        hitCap1 = (regAddr == `VCA_OFF_PVC_CAP1);
        hitCap2 = (regAddr == `VCA_OFF_PVC_CAP2);
        hitRes0 = (regAddr == `VCA_OFF_RES_CAP0);
        tblRel  = regAddr - tblBase;
        tblIdx  = tblRel[IDX_W+1:2];
        // the table only exists while exactly one extended VC is present
        hitTbl  = oneExtVc
               && (regAddr >= tblBase)
               && (tblRel[1:0] == 2'h0)
               && ((tblRel >> 2) < `VCA_ADDR_W'(WORDS));
    end

    ////////////////////////////////////////////////////////////////////////////
    // control word, load request and loader

    logic [2:0]       sel_q, sel_d;
    logic             loadReq;
    logic             ldBusy;
    logic             ldCopyEn;
    logic [IDX_W-1:0] ldCopyIdx;
    logic             ldDone;

    always_comb begin
        sel_d   = sel_q;
        loadReq = 1'b0;
        if (regWr && hitCtrl) begin
            // only the selector is stored; reserved bits are dropped
            sel_d   = regWrData[`VCA_CTRL_SEL_LSB +: 3];
            loadReq = regWrData[`VCA_CTRL_LOAD_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= `VCA_CTRL_SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    // a request during a load is dropped; the running copy already
    // takes each word as it stands when its turn comes
    vca_table_loader #(
        .WORDS   (WORDS),
        .IDX_W   (IDX_W)
    ) uLoader (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .start   (loadReq && !ldBusy),
        .busy    (ldBusy),
        .copyEn  (ldCopyEn),
        .copyIdx (ldCopyIdx),
        .done    (ldDone)
    );

    vca_pkg::vca_scheme_t schemeEff;

    vca_scheme_decode uDecode (
        .selRaw   (sel_q),
        .wrrAvail (low_priority_vc_group_q != 3'h0),
        .scheme   (schemeEff)
    );

    ////////////////////////////////////////////////////////////////////////////
    // programmed table: software writes land here and read back from here

    logic [`VCA_DATA_W-1:0] shadow_q [WORDS];
    logic [`VCA_DATA_W-1:0] shadow_d [WORDS];
    logic                   tblWrite;

    always_comb begin
        tblWrite = regWr && hitTbl;
        for (int i = 0; i < WORDS; i++) begin
            shadow_d[i] = shadow_q[i];
            if (tblWrite && tblIdx == IDX_W'(i)) begin
                shadow_d[i] = regWrData;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < WORDS; i++) begin
                shadow_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < WORDS; i++) begin
                shadow_q[i] <= shadow_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // active table: only the loader moves it, so the arbiter never sees
    // a half-programmed table while software is still writing entries

    logic [`VCA_DATA_W-1:0] active_q [WORDS];
    logic [`VCA_DATA_W-1:0] active_d [WORDS];

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            active_d[i] = active_q[i];
            if (ldCopyEn && ldCopyIdx == IDX_W'(i)) begin
                active_d[i] = shadow_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < WORDS; i++) begin
                active_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < WORDS; i++) begin
                active_q[i] <= active_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // table status flag and sticky loaded flag

    logic tblStat_q, tblStat_d;
    logic loaded_q,  loaded_d;

    always_comb begin
        // a table write in the finishing cycle keeps the flag set
        tblStat_d = (tblStat_q && !ldDone) || tblWrite;
        loaded_d  = loaded_q || ldDone;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tblStat_q <= 1'b0;
            loaded_q  <= 1'b0;
        end else begin
            tblStat_q <= tblStat_d;
            loaded_q  <= loaded_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arbiter view: whole words packed, then cut to the table's own width

    logic [WORDS*`VCA_DATA_W-1:0] activeFlat;

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            activeFlat[i*`VCA_DATA_W +: `VCA_DATA_W] = active_q[i];
        end
        arbTable = activeFlat[TBL_BITS-1:0];
    end

    assign arbCfg = '{scheme: schemeEff, tableLoaded: loaded_q, loadBusy: ldBusy};

    ////////////////////////////////////////////////////////////////////////////
    // read path: data stand in the cycle after the strobe

    logic [`VCA_DATA_W-1:0] rdData_q, rdData_d;
    logic [`VCA_DATA_W-1:0] ctrlWord;

    always_comb begin
        ctrlWord = '0;
        ctrlWord[`VCA_CTRL_LOAD_BIT]     = 1'b0;
        ctrlWord[`VCA_CTRL_SEL_LSB +: 3] = sel_q;
        ctrlWord[`VCA_STAT_TBL_BIT]      = tblStat_q;

        rdData_d = '0;
        if (regRd) begin
            if (hitCap1) begin
                rdData_d = cap1Word;
            end else if (hitCap2) begin
                rdData_d = cap2Word;
            end else if (hitCtrl) begin
                rdData_d = ctrlWord;
            end else if (hitRes0) begin
                rdData_d = resCap0Word;
            end else if (hitTbl) begin
                // software sees what it programmed, even before a load
                rdData_d = shadow_q[tblIdx];
            end else begin
                // unmapped addresses answer zero
                rdData_d = '0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

endmodule : vca_vc_arb_regs

// ---- vca_consts.svh ----
`ifndef VCA_CONSTS_SVH
`define VCA_CONSTS_SVH

// register bus geometry
`define VCA_ADDR_W              12
`define VCA_DATA_W              32

// register byte addresses
`define VCA_CAP_BASE            12'h140
`define VCA_OFF_PVC_CAP1        12'h144
`define VCA_OFF_PVC_CAP2        12'h148
`define VCA_OFF_PVC_CTRL_STAT   12'h14C
`define VCA_OFF_RES_CAP0        12'h150

// port VC capability one fields
`define VCA_CAP1_EXT_LSB        0
`define VCA_CAP1_LOW_PRIORITY_VC_GROUP_LSB       4
`define VCA_CAP1_ENTRY_LSB      10
`define VCA_CAP1_ENTRY_SIZE     2'h2

// port VC capability two fields
`define VCA_CAP2_ARBCAP_LSB     0
`define VCA_CAP2_TBLOFF_LSB     24
`define VCA_VC_ARB_CAP_NONE     8'h00
`define VCA_VC_ARB_CAP_ONE      8'h03
`define VCA_VC_TBL_OFF_NONE     8'h00
`define VCA_VC_TBL_OFF_ONE      8'h03

// port VC control and status fields
`define VCA_CTRL_LOAD_BIT       0
`define VCA_CTRL_SEL_LSB        1
`define VCA_CTRL_SEL_RESET      3'h0
`define VCA_STAT_TBL_BIT        16

// VC resource capability zero fields
`define VCA_RC0_PORTCAP_LSB     0
`define VCA_RC0_APS_BIT         14
`define VCA_RC0_SNOOP_BIT       15
`define VCA_RC0_SLOTS_LSB       16
`define VCA_RC0_TBLOFF_LSB      24
`define VCA_PORT_ARB_CAP0       8'h09
`define VCA_MAX_TIME_SLOTS      7'h7F
`define VCA_PORT_TBL_OFF0       8'h04

// table geometry and load pacing
`define VCA_TBL_PHASES          32
`define VCA_TBL_ENTRY_W         4
`define VCA_UNIT_SHIFT          4
`define VCA_LOAD_GAP_CYCLES     1

`endif

// ---- vca_pkg.sv ----
package vca_pkg;

    typedef enum logic [1:0] {
        VCA_ARB_FIXED_RR,
        VCA_ARB_WRR32
    } vca_scheme_t;

    typedef enum logic [1:0] {
        VCA_LD_IDLE,
        VCA_LD_COPY,
        VCA_LD_GAP
    } vca_ld_state_t;

    typedef struct packed {
        vca_scheme_t scheme;
        logic        tableLoaded;
        logic        loadBusy;
    } vca_arb_cfg_t;

endpackage : vca_pkg

// ---- vca_scheme_decode.sv ----
`timescale 1ns/1ps
`include "vca_consts.svh"

module vca_scheme_decode (
    input  wire logic [2:0]          selRaw,
    input  wire logic                wrrAvail,
    output vca_pkg::vca_scheme_t     scheme
);

    // unsupported codes fall back to the default scheme
    always_comb begin
        if (selRaw == 3'h1 && wrrAvail) begin
            scheme = vca_pkg::VCA_ARB_WRR32;
        end else begin
            scheme = vca_pkg::VCA_ARB_FIXED_RR;
        end
    end

endmodule : vca_scheme_decode

// ---- vca_table_loader.sv ----
`timescale 1ns/1ps
`include "vca_consts.svh"

module vca_table_loader #(
    parameter int WORDS = 4,
    parameter int IDX_W = 2
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              start,
    output logic                   busy,
    output logic                   copyEn,
    output logic [IDX_W-1:0]       copyIdx,
    output logic                   done
);

    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(WORDS - 1);

    vca_pkg::vca_ld_state_t state_q, state_d;
    logic [IDX_W-1:0]       idx_q, idx_d;
    logic                   done_q, done_d;

    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        done_d  = 1'b0;
        case (state_q)
            vca_pkg::VCA_LD_IDLE: begin
                if (start) begin
                    state_d = vca_pkg::VCA_LD_COPY;
                    idx_d   = '0;
                end
            end
            vca_pkg::VCA_LD_COPY: begin
                if (idx_q == LAST_IDX) begin
                    state_d = vca_pkg::VCA_LD_GAP;
                end else begin
                    idx_d = idx_q + IDX_W'(1);
                end
            end
            vca_pkg::VCA_LD_GAP: begin
                // one settle cycle before the arbiter may trust the table
                state_d = vca_pkg::VCA_LD_IDLE;
                done_d  = 1'b1;
            end
            default: begin
                state_d = vca_pkg::VCA_LD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= vca_pkg::VCA_LD_IDLE;
            idx_q   <= '0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
            done_q  <= done_d;
        end
    end

    assign busy    = (state_q != vca_pkg::VCA_LD_IDLE) || done_q;
    assign copyEn  = (state_q == vca_pkg::VCA_LD_COPY);
    assign copyIdx = idx_q;
    assign done    = done_q;

endmodule : vca_table_loader

// ---- vca_arb_regs_asserts.sv ----
`timescale 1ns/1ps
module vca_arb_regs_chk #(
    parameter int PHASES  = 32,
    parameter int ENTRY_W = 4
) (
    input wire logic                      clk_sys,
    input wire logic                      rst_b,
    input wire logic [11:0]               regAddr,
    input wire logic [31:0]               regWrData,
    input wire logic                      regWr,
    input wire logic                      regRd,
    input wire logic [31:0]               regRdData,
    input wire logic [2:0]                extVcCount,
    input wire logic [2:0]                lowPriorityVcGroup,
    input wire vca_pkg::vca_arb_cfg_t     arbCfg,
    input wire logic [PHASES*ENTRY_W-1:0] arbTable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_idle_read_zero: assert property (
        !regRd |=> regRdData == 32'h0) else $error("read data not zero when idle");
    a_load_bit_zero: assert property (
        regRd && regAddr == 12'h14C |=> !regRdData[0]) else $error("load bit read as one");
    a_ctrl_rsvd_zero: assert property (
        regRd && regAddr == 12'h14C |=> regRdData[15:4] == 12'h0 && regRdData[31:17] == 15'h0)
        else $error("reserved control bits not zero");
    a_res_cap_word: assert property (
        regRd && regAddr == 12'h150 |=> regRdData == 32'h047F0009)
        else $error("resource capability word wrong");
    // count input is flopped once, so the read sees the value from the cycle before
    a_cap2_follows_ext: assert property (
        regRd && regAddr == 12'h148 && $past(rst_b) |=>
        regRdData == (($past(extVcCount, 2) == 3'h1) ? 32'h03000003 : 32'h0))
        else $error("capability two word wrong");
    a_unmapped_zero: assert property (
        regRd && regAddr < 12'h140 |=> regRdData == 32'h0) else $error("unmapped read not zero");
    a_status_on_write: assert property (
        regWr && regAddr[11:4] == 8'h17 && regAddr[1:0] == 2'h0 && !arbCfg.loadBusy
        && $past(extVcCount) == 3'h1 && $past(rst_b)
        ##2 regRd && regAddr == 12'h14C |=> regRdData[16]) else $error("table status not set");
    a_load_busy_span: assert property (
        regWr && regAddr == 12'h14C && regWrData[0] && !arbCfg.loadBusy |=>
        arbCfg.loadBusy [*6] ##1 (!arbCfg.loadBusy && arbCfg.tableLoaded))
        else $error("load sequence length wrong");
    a_scheme_default: assert property (
        regWr && regAddr == 12'h14C && regWrData[3:1] != 3'h1 |=>
        arbCfg.scheme == vca_pkg::VCA_ARB_FIXED_RR) else $error("default scheme not used");
    a_scheme_wrr: assert property (
        regWr && regAddr == 12'h14C && regWrData[3:1] == 3'h1 && lowPriorityVcGroup != 3'h0
        ##1 lowPriorityVcGroup != 3'h0 |-> arbCfg.scheme == vca_pkg::VCA_ARB_WRR32)
        else $error("weighted scheme not selected");
    a_table_on_load: assert property (
        $changed(arbTable) |-> $past(arbCfg.loadBusy)) else $error("table moved without load");
endmodule : vca_arb_regs_chk

bind vca_vc_arb_regs vca_arb_regs_chk #(.PHASES(PHASES), .ENTRY_W(ENTRY_W)) u_vca_arb_regs_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .extVcCount(extVcCount),
    .lowPriorityVcGroup(lowPriorityVcGroup), .arbCfg(arbCfg), .arbTable(arbTable));

// ---- vca_host_model.sv ----
`timescale 1ns/1ps
module vca_host_model (
    input  wire logic        clk_sys,
    output logic [11:0]      regAddr,
    output logic [31:0]      regWrData,
    output logic             regWr,
    output logic             regRd,
    input  wire logic [31:0] regRdData
);
    initial begin
        regAddr   = 12'hFFF;
        regWrData = 32'h0;
        regWr     = 1'b0;
        regRd     = 1'b0;
    end

    // idle bus carries the inverse of the last value, never a stale copy
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk_sys);
        regWr     <= 1'b0;
        regAddr   <= ~a;
        regWrData <= ~d;
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdData;
    endtask : rd
endmodule : vca_host_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic                  clk_sys;
    logic                  rst_b;
    logic [11:0]           regAddr;
    logic [31:0]           regWrData;
    logic                  regWr;
    logic                  regRd;
    logic [31:0]           regRdData;
    logic [2:0]            extVcCount;
    logic [2:0]            lowPriorityVcGroup;
    vca_pkg::vca_arb_cfg_t arbCfg;
    logic [127:0]          arbTable;
    int                    err_count;
    int                    samples_checked;
    logic [31:0]           tw [4] = '{32'h76543210, 32'hFEDCBA98, 32'h0F1E2D3C, 32'hA5A55A5A};

    vca_vc_arb_regs u_vca_vc_arb_regs (
        .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .extVcCount(extVcCount),
        .lowPriorityVcGroup(lowPriorityVcGroup), .arbCfg(arbCfg), .arbTable(arbTable));
    vca_host_model u_vca_host_model (
        .clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic chkRd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        u_vca_host_model.rd(a, d);
        chk(128'(d), 128'(exp));
    endtask : chkRd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // whole run is about a hundred cycles; this leaves wide margin
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        end_sim();
    end

    initial begin
        err_count          = 0;
        samples_checked    = 0;
        rst_b              = 1'b0;
        extVcCount         = 3'h1;
        lowPriorityVcGroup = 3'h1;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        chkRd(12'h144, 32'h00000811);
        chkRd(12'h148, 32'h03000003);
        chkRd(12'h150, 32'h047F0009);
        chkRd(12'h14C, 32'h00000000);
        chkRd(12'h100, 32'h00000000);
        u_vca_host_model.wr(12'h148, 32'hFFFFFFFF);
        chkRd(12'h148, 32'h03000003);
        for (int s = 0; s < 8; s++) begin
            u_vca_host_model.wr(12'h14C, {16'h0, 12'hFFF, 3'(s), 1'b0});
            chk(128'(arbCfg.scheme), (s == 1) ? 128'h1 : 128'h0);
            chkRd(12'h14C, {28'h0, 3'(s), 1'b0});
        end
        @(posedge clk_sys);
        lowPriorityVcGroup <= 3'h0;
        u_vca_host_model.wr(12'h14C, 32'h00000002);
        chk(128'(arbCfg.scheme), 128'h0);
        @(posedge clk_sys);
        lowPriorityVcGroup <= 3'h1;
        u_vca_host_model.wr(12'h14C, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            u_vca_host_model.wr(12'h170 + 12'(4 * i), tw[i]);
        end
        chkRd(12'h14C, 32'h00010000);
        for (int i = 0; i < 4; i++) begin
            chkRd(12'h170 + 12'(4 * i), tw[i]);
        end
        chk(arbTable, 128'h0);
        u_vca_host_model.wr(12'h14C, 32'h00000001);
        chk(128'(arbCfg.loadBusy), 128'h1);
        for (int n = 0; n < 20 && arbCfg.loadBusy !== 1'b0; n++) begin
            @(posedge clk_sys);
            #1;
        end
        #1;
        chk(128'(arbCfg.loadBusy), 128'h0);
        chk(arbTable, {tw[3], tw[2], tw[1], tw[0]});
        chk(128'(arbCfg.tableLoaded), 128'h1);
        chkRd(12'h14C, 32'h00000000);
        @(posedge clk_sys);
        extVcCount <= 3'h0;
        @(posedge clk_sys);
        chkRd(12'h148, 32'h00000000);
        chkRd(12'h170, 32'h00000000);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(arbTable, 128'h0);
        rst_b <= 1'b1;
        chkRd(12'h14C, 32'h00000000);
        end_sim();
    end
endmodule : tb_top
